// >>> pkg/pcgs_pkg.sv
// Package: register map, field layout, reset values and timing for the gear and smoothing block
`default_nettype none

package pcgs_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ         = 250;
  localparam int unsigned SMOOTH_UNIT_NS  = 10_000_000;  // One smoothing step is 10 ms
  localparam int unsigned FILT_TICK_NS    = 1_000_000;   // Filter update period, 1 ms
  localparam int unsigned FILT_TICK_CYC   = FILT_TICK_NS / 1000 * CLK_MHZ;
  localparam int unsigned SMOOTH_SCALE    = SMOOTH_UNIT_NS / FILT_TICK_NS;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [9:0]  IDX_SMOOTH      = 10'h110;
  localparam logic [9:0]  IDX_NUM1        = 10'h158;
  localparam logic [9:0]  IDX_DEN         = 10'h15A;
  localparam logic [9:0]  IDX_CTRL        = 10'h200;
  localparam logic [9:0]  IDX_STAT        = 10'h201;
  localparam logic [9:0]  IDX_GEAR_POS    = 10'h202;
  localparam logic [9:0]  IDX_CMD_POS     = 10'h203;

  localparam logic [11:0] ADDR_SMOOTH     = {IDX_SMOOTH, 2'h0};
  localparam logic [11:0] ADDR_NUM1       = {IDX_NUM1, 2'h0};
  localparam logic [11:0] ADDR_DEN        = {IDX_DEN, 2'h0};
  localparam logic [11:0] ADDR_CTRL       = {IDX_CTRL, 2'h0};
  localparam logic [11:0] ADDR_STAT       = {IDX_STAT, 2'h0};
  localparam logic [11:0] ADDR_GEAR_POS   = {IDX_GEAR_POS, 2'h0};
  localparam logic [11:0] ADDR_CMD_POS    = {IDX_CMD_POS, 2'h0};

  // ----------------------------------------------------------------
  // Reset values and legal ranges
  // ----------------------------------------------------------------
  localparam logic [15:0] SMOOTH_RST      = 16'h0000;
  localparam logic [15:0] SMOOTH_MAX      = 16'h03E8;
  localparam logic [31:0] NUM1_RST        = 32'h0000_0010;
  localparam logic [31:0] NUM1_MAX        = 32'h03FF_FFFF;
  localparam logic [31:0] DEN_RST         = 32'h0000_000A;
  localparam logic [31:0] DEN_MAX         = 32'h7FFF_FFFF;
  localparam logic [3:0]  CTRL_RST        = 4'h0;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_SERVO_BIT  = 0;
  localparam int unsigned CTRL_PT_BIT     = 1;
  localparam int unsigned CTRL_SEL_LSB    = 2;
  localparam int unsigned CTRL_W          = 4;
  localparam int unsigned STAT_REFUSE_BIT = 0;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic step;  // One input pulse this cycle
    logic dir;   // 1 = reverse
  } pcgs_pulse_type;

endpackage

`default_nettype wire

// >>> hw/pcgs_lpf.sv
// First-order position command smoothing filter with bypass
`default_nettype none

module pcgs_lpf #(
  parameter int unsigned POS_W = 48
) (
  // Clock and reset
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  // Control
  input  wire logic                    tick,
  input  wire logic [15:0]             tau,
  // Position in and out
  input  wire logic signed [POS_W-1:0] target,
  output logic signed [POS_W-1:0]      smoothed
);

  // ----------------------------------------------------------------
  // Step towards the target
  // ----------------------------------------------------------------
  logic signed [POS_W-1:0] y_r;
  logic signed [POS_W-1:0] y_nxt;
  logic signed [POS_W:0]   diff;
  logic signed [POS_W:0]   div_s;
  logic signed [POS_W:0]   quot;
  logic signed [POS_W:0]   step;
  logic [19:0]             div_u;

  // Divisor in filter ticks; tau of 0 never reaches the division
  assign div_u = 20'(tau * pcgs_pkg::SMOOTH_SCALE);
  assign div_s = $signed({{(POS_W-19){1'b0}}, div_u});
  assign diff  = {target[POS_W-1], target} - {y_r[POS_W-1], y_r};
  assign quot  = (tau == 16'h0000) ? diff : diff / div_s;
  // Never stall short of the target, so total travel is kept
  assign step  = (quot == '0 && diff != '0) ? (diff[POS_W] ? '1 : (POS_W+1)'(1)) : quot;

  // Bypass follows the target so enabling smoothing causes no jump
  assign y_nxt = (tau == 16'h0000) ? target :
                 tick ? POS_W'(y_r + step[POS_W-1:0]) : y_r;

  // Filter state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      y_r <= '0;
    end else begin
      y_r <= y_nxt;
    end
  end

  assign smoothed = y_r;

endmodule

`default_nettype wire

// >>> hw/pcgs_top.sv
// Position command gear scaling and smoothing with APB register access
// Function
// - Command equals input count times N over M
// - Numerator from first or extra; single denominator
// - First numerator 32-bit, 1..2^26-1, resets 16
// - Denominator 32-bit, 1..2^31-1, resets 10
// - Pulse-train mode: numerator writable only servo on
// - Pulse-train mode: denominator locked while servo on
// - Smoothing 16-bit, 0..1000, 10 ms units, resets 0
// - Smoothing zero bypasses the filter
//
// Design decision made here: register access over APB.
`default_nettype none

module pcgs_top #(
  parameter int unsigned ADDR_W    = 12,
  parameter int unsigned POS_W     = 48,
  parameter int unsigned N_EXTRA   = 3,
  parameter int unsigned TICK_CYC  = pcgs_pkg::FILT_TICK_CYC
) (
  // Clock and reset
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  // APB slave
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [ADDR_W-1:0]       paddr,
  input  wire logic [31:0]             pwdata,
  output logic [31:0]                  prdata,
  output logic                         pready,
  output logic                         pslverr,
  // Pulse command input
  input  wire pcgs_pkg::pcgs_pulse_type pulse_in,
  input  wire logic [31:0]             extra_numerator [N_EXTRA],
  // Position command output
  output logic signed [POS_W-1:0]      gear_pos,
  output logic signed [POS_W-1:0]      pos_cmd
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [15:0]                smooth_r;
  logic [31:0]                num1_r;
  logic [31:0]                den_r;
  logic [pcgs_pkg::CTRL_W-1:0] ctrl_r;
  logic                       refuse_r;
  logic                       refuse_nxt;
  logic signed [34:0]         rem_r;
  logic signed [34:0]         rem_nxt;
  logic signed [POS_W-1:0]    gear_pos_r;
  logic signed [POS_W-1:0]    gear_pos_nxt;
  logic [$clog2(TICK_CYC)-1:0] tick_cnt_r;
  logic                       tick;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire        wr_acc    = psel && penable && pwrite;
  wire [11:0] addr      = 12'(paddr);
  wire        hit_smth  = (addr == pcgs_pkg::ADDR_SMOOTH);
  wire        hit_num1  = (addr == pcgs_pkg::ADDR_NUM1);
  wire        hit_den   = (addr == pcgs_pkg::ADDR_DEN);
  wire        hit_ctrl  = (addr == pcgs_pkg::ADDR_CTRL);
  wire        hit_stat  = (addr == pcgs_pkg::ADDR_STAT);
  wire        hit_gpos  = (addr == pcgs_pkg::ADDR_GEAR_POS);
  wire        hit_cpos  = (addr == pcgs_pkg::ADDR_CMD_POS);
  wire        hit_any   = hit_smth | hit_num1 | hit_den | hit_ctrl | hit_stat | hit_gpos | hit_cpos;

  // Drive state as seen by the parameter lock
  wire        servo_on  = ctrl_r[pcgs_pkg::CTRL_SERVO_BIT];
  wire        pt_mode   = ctrl_r[pcgs_pkg::CTRL_PT_BIT];
  wire [1:0]  num_sel   = ctrl_r[pcgs_pkg::CTRL_SEL_LSB +: 2];

  // Write acceptance: range and servo-state checks
  wire smth_ok = (pwdata[31:16] == 16'h0000) && (pwdata[15:0] <= pcgs_pkg::SMOOTH_MAX);
  wire num1_ok = (pwdata != 32'h0) && (pwdata <= pcgs_pkg::NUM1_MAX)
                 && (!pt_mode || servo_on);
  wire den_ok  = (pwdata != 32'h0) && (pwdata <= pcgs_pkg::DEN_MAX)
                 && !(pt_mode && servo_on);
  wire ro_hit  = hit_gpos | hit_cpos;
  wire refused = (hit_smth && !smth_ok) || (hit_num1 && !num1_ok) || (hit_den && !den_ok) || ro_hit;

  wire wr_smth = wr_acc && hit_smth && smth_ok;
  wire wr_num1 = wr_acc && hit_num1 && num1_ok;
  wire wr_den  = wr_acc && hit_den && den_ok;
  wire wr_ctrl = wr_acc && hit_ctrl;
  wire wr_stat = wr_acc && hit_stat;
  wire bad_wr  = wr_acc && refused;

  // Zero-wait answers; error on unmapped or refused access
  assign pready  = 1'b1;
  assign pslverr = psel && penable && (!hit_any || (pwrite && refused));

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  wire [31:0] rd_mux = hit_smth ? {16'h0000, smooth_r} :
                       hit_num1 ? num1_r :
                       hit_den  ? den_r :
                       hit_ctrl ? {{(32-pcgs_pkg::CTRL_W){1'b0}}, ctrl_r} :
                       hit_stat ? {31'h0, refuse_r} :
                       hit_gpos ? gear_pos_r[31:0] :
                       hit_cpos ? pos_cmd[31:0] : 32'h0000_0000;

  // Read data latched in setup so it comes from a flip-flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // Setting registers
  // ----------------------------------------------------------------
  // Refused-write flag: new refusal wins over a clear
  assign refuse_nxt = bad_wr ? 1'b1 :
                      (wr_stat && pwdata[pcgs_pkg::STAT_REFUSE_BIT]) ? 1'b0 : refuse_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      smooth_r <= pcgs_pkg::SMOOTH_RST;
      num1_r   <= pcgs_pkg::NUM1_RST;
      den_r    <= pcgs_pkg::DEN_RST;
      ctrl_r   <= pcgs_pkg::CTRL_RST;
      refuse_r <= 1'b0;
    end else begin
      if (wr_smth) smooth_r <= pwdata[15:0];
      if (wr_num1) num1_r <= pwdata;
      if (wr_den) den_r <= pwdata;
      if (wr_ctrl) ctrl_r <= pwdata[pcgs_pkg::CTRL_W-1:0];
      refuse_r <= refuse_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Numerator selection
  // ----------------------------------------------------------------
  logic [31:0] num_tab [N_EXTRA+1];

  assign num_tab[0] = num1_r;
  // Extra numerators follow the first one in the selection table
  genvar gi;
  generate
    for (gi = 0; gi < N_EXTRA; gi++) begin : g_num
      assign num_tab[gi+1] = extra_numerator[gi];
    end
  endgenerate

  // Out-of-range selection falls back to the first numerator
  wire [31:0] active_num = (32'(num_sel) <= N_EXTRA) ? num_tab[num_sel] : num1_r;

  // ----------------------------------------------------------------
  // Gear scaling with carried remainder
  // ----------------------------------------------------------------
  wire signed [34:0] num_s  = $signed({3'b000, active_num});
  wire signed [34:0] den_s  = $signed({3'b000, den_r});
  wire signed [34:0] sum    = pulse_in.dir ? rem_r - num_s : rem_r + num_s;
  wire signed [34:0] quot   = sum / den_s;
  wire signed [34:0] remain = sum % den_s;

  // Truncating division keeps quot*M + remain equal to the sum
  assign rem_nxt      = pulse_in.step ? remain : rem_r;
  assign gear_pos_nxt = pulse_in.step ? POS_W'(gear_pos_r + {{(POS_W-35){quot[34]}}, quot}) : gear_pos_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rem_r      <= '0;
      gear_pos_r <= '0;
    end else begin
      rem_r      <= rem_nxt;
      gear_pos_r <= gear_pos_nxt;
    end
  end

  assign gear_pos = gear_pos_r;

  // ----------------------------------------------------------------
  // Filter tick and smoothing
  // ----------------------------------------------------------------
  assign tick = (tick_cnt_r == $bits(tick_cnt_r)'(TICK_CYC - 1));

  // Free-running filter update period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_r <= '0;
    end else begin
      tick_cnt_r <= tick ? '0 : tick_cnt_r + 1'b1;
    end
  end

  pcgs_lpf #(
    .POS_W    (POS_W)
  ) u_lpf (
    .pclk     (pclk),
    .presetn  (presetn),
    .tick     (tick),
    .tau      (smooth_r),
    .target   (gear_pos_r),
    .smoothed (pos_cmd)
  );

endmodule

`default_nettype wire

// >>> dv/pcgs_top_asserts.sv
// Port assertions for the gear scaling and smoothing block
`default_nettype none

module pcgs_top_asserts #(
  parameter int unsigned ADDR_W  = 12,
  parameter int unsigned POS_W   = 48,
  parameter int unsigned N_EXTRA = 3
) (
  // Clock and reset
  input wire logic                     pclk,
  input wire logic                     presetn,
  // APB
  input wire logic                     psel,
  input wire logic                     penable,
  input wire logic                     pwrite,
  input wire logic [ADDR_W-1:0]        paddr,
  input wire logic [31:0]              pwdata,
  input wire logic [31:0]              prdata,
  input wire logic                     pready,
  input wire logic                     pslverr,
  // Pulses and positions
  input wire pcgs_pkg::pcgs_pulse_type pulse_in,
  input wire logic [31:0]              extra_numerator [N_EXTRA],
  input wire logic signed [POS_W-1:0]  gear_pos,
  input wire logic signed [POS_W-1:0]  pos_cmd
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Write decode
  wire wr = psel && penable && pwrite;
  wire ok = wr && !pslverr;
  wire num = wr && paddr == pcgs_pkg::ADDR_NUM1;
  wire den = wr && paddr == pcgs_pkg::ADDR_DEN;

  // Shadow of accepted mode and smoothing writes
  logic [1:0] mode_r;
  logic       smooth_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= 2'h0;
      smooth_r <= 1'h0;
    end else begin
      if (ok && paddr == pcgs_pkg::ADDR_CTRL) mode_r <= pwdata[1:0];
      if (ok && paddr == pcgs_pkg::ADDR_SMOOTH) smooth_r <= pwdata != 32'h0;
    end
  end

  hold_gear_a: assert property (!pulse_in.step |=> $stable(gear_pos))
    else $error("Position moved without a pulse");
  fwd_gear_a: assert property (pulse_in.step && !pulse_in.dir |=> gear_pos >= $past(gear_pos))
    else $error("Forward pulse moved position back");
  rev_gear_a: assert property (pulse_in.step && pulse_in.dir |=> gear_pos <= $past(gear_pos))
    else $error("Reverse pulse moved position on");
  num_lock_a: assert property (num && mode_r == 2'h2 |-> pslverr)
    else $error("Numerator taken with servo off");
  den_lock_a: assert property (den && mode_r == 2'h3 |-> pslverr)
    else $error("Denominator taken with servo on");
  num_range_a: assert property (num && (pwdata == 32'h0 || pwdata > pcgs_pkg::NUM1_MAX) |-> pslverr)
    else $error("Numerator out of range taken");
  den_range_a: assert property (den && (pwdata == 32'h0 || pwdata > pcgs_pkg::DEN_MAX) |-> pslverr)
    else $error("Denominator out of range taken");
  smooth_range_a: assert property (wr && paddr == pcgs_pkg::ADDR_SMOOTH && pwdata > 32'h3E8 |-> pslverr)
    else $error("Smoothing out of range taken");
  bypass_a: assert property (!smooth_r |=> pos_cmd == $past(gear_pos))
    else $error("Bypass did not follow position");
  lpf_rise_a: assert property (smooth_r && pos_cmd <= gear_pos |=> pos_cmd >= $past(pos_cmd))
    else $error("Filter moved away from target");

  // Main scenarios
  cover property (ok && paddr == pcgs_pkg::ADDR_NUM1 && mode_r == 2'h3);
  cover property (smooth_r && pos_cmd != gear_pos);
  cover property (pulse_in.step && pulse_in.dir);
endmodule

bind pcgs_top pcgs_top_asserts #(.ADDR_W(ADDR_W), .POS_W(POS_W), .N_EXTRA(N_EXTRA)) chk_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pulse_in(pulse_in), .extra_numerator(extra_numerator), .gear_pos(gear_pos), .pos_cmd(pos_cmd)
);

`default_nettype wire

// >>> dv/pcgs_pulse_src.sv
// Pulse-train controller model feeding the command pulse input
`default_nettype none

module pcgs_pulse_src (
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // Burst request
  input  wire logic              start,
  input  wire logic [15:0]       count,
  input  wire logic              dir,
  input  wire logic [3:0]        gap,
  // Pulse line
  output logic                   busy,
  output var pcgs_pkg::pcgs_pulse_type pulse
);
  logic [15:0] left_r;
  logic [3:0]  wait_r;

  // Busy while pulses are owed or one is on the line
  assign busy = (left_r != 16'h0) || pulse.step;

  // One pulse a cycle at most, spaced by gap idle cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      left_r <= 16'h0;
      wait_r <= 4'h0;
      pulse <= '0;
    end else if (start) begin
      left_r <= count;
      wait_r <= 4'h0;
    end else if (left_r != 16'h0 && wait_r == 4'h0) begin
      pulse.step <= 1'h1;
      pulse.dir <= dir;
      left_r <= left_r - 16'h1;
      wait_r <= gap;
    end else begin
      pulse.step <= 1'h0;
      pulse.dir <= ~pulse.dir; // Idle direction wanders
      if (wait_r != 4'h0) wait_r <= wait_r - 4'h1;
    end
  end
endmodule

`default_nettype wire

// >>> dv/test_pcgs_top.sv
// Self-checking bench for the gear scaling and smoothing block
`default_nettype none

module test_pcgs_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                     pclk, presetn, psel, penable, pwrite;
  logic                     pready, pslverr, er, start, dir, busy;
  logic [11:0]              paddr;
  logic [31:0]              pwdata, prdata, rd;
  logic [31:0]              extra [3];
  logic [15:0]              count;
  logic [3:0]               gap;
  logic signed [47:0]       gear_pos, pos_cmd;
  pcgs_pkg::pcgs_pulse_type pulse;
  int                       errors, checked;

  pcgs_top #(.TICK_CYC(8)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pulse_in(pulse), .extra_numerator(extra), .gear_pos(gear_pos), .pos_cmd(pos_cmd));
  pcgs_pulse_src src_u (
    .pclk(pclk), .presetn(presetn), .start(start), .count(count), .dir(dir), .gap(gap),
    .busy(busy), .pulse(pulse));

  initial begin
    pclk = 1'h0;
    forever #2 pclk = ~pclk;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic results;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    for (i = 0; i < 50; i++) begin
      @(posedge pclk);
      if (pready === 1'h1) break;
    end
    if (i == 50) begin
      errors++;
      results();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic e);
    apb(1'h1, a, d);
    chk({47'h0, er}, {47'h0, e});
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk({16'h0, rd}, {16'h0, e});
  endtask

  task automatic pulses(input int n, input logic d, input logic [3:0] g);
    int i;
    @(posedge pclk);
    start <= 1'h1;
    count <= n[15:0];
    dir <= d;
    gap <= g;
    @(posedge pclk);
    start <= 1'h0;
    // Busy is looked at mid-cycle, clear of the edge that updates it
    for (i = 0; i < 2000; i++) begin
      @(negedge pclk);
      if (!busy) break;
    end
    if (i == 2000) begin
      errors++;
      results();
    end
    @(negedge pclk);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    rdchk(pcgs_pkg::ADDR_SMOOTH, 32'h0);
    rdchk(pcgs_pkg::ADDR_NUM1, 32'h10);
    rdchk(pcgs_pkg::ADDR_DEN, 32'hA);
    rdchk(12'h004, 32'h0);
    wr(pcgs_pkg::ADDR_GEAR_POS, 32'h5, 1'h1);
  endtask

  task automatic t_gear;
    logic [47:0] e;
    wr(pcgs_pkg::ADDR_NUM1, 32'h1, 1'h0);
    wr(pcgs_pkg::ADDR_DEN, 32'h2, 1'h0);
    pulses(3, 1'h0, 4'h0);
    chk(gear_pos, 48'h1);
    pulses(3, 1'h0, 4'h2);
    chk(gear_pos, 48'h3);
    chk(pos_cmd, 48'h3);
    pulses(4, 1'h1, 4'h0);
    chk(gear_pos, 48'h1);
    e = 48'h1;
    for (int s = 1; s <= 3; s++) begin
      wr(pcgs_pkg::ADDR_CTRL, {28'h0, s[1:0], 2'h0}, 1'h0);
      pulses(2, 1'h0, 4'h1);
      e = e + extra[s-1];
      chk(gear_pos, e);
    end
    wr(pcgs_pkg::ADDR_CTRL, 32'h0, 1'h0);
  endtask

  task automatic t_lock;
    wr(pcgs_pkg::ADDR_CTRL, 32'h3, 1'h0);
    wr(pcgs_pkg::ADDR_NUM1, 32'h3, 1'h0);
    wr(pcgs_pkg::ADDR_DEN, 32'h4, 1'h1);
    rdchk(pcgs_pkg::ADDR_DEN, 32'h2);
    rdchk(pcgs_pkg::ADDR_STAT, 32'h1);
    wr(pcgs_pkg::ADDR_STAT, 32'h1, 1'h0);
    rdchk(pcgs_pkg::ADDR_STAT, 32'h0);
    wr(pcgs_pkg::ADDR_CTRL, 32'h2, 1'h0);
    wr(pcgs_pkg::ADDR_NUM1, 32'h5, 1'h1);
    rdchk(pcgs_pkg::ADDR_NUM1, 32'h3);
    wr(pcgs_pkg::ADDR_DEN, 32'h6, 1'h0);
    wr(pcgs_pkg::ADDR_CTRL, 32'h0, 1'h0);
    wr(pcgs_pkg::ADDR_NUM1, 32'h0, 1'h1);
    wr(pcgs_pkg::ADDR_NUM1, 32'h0400_0000, 1'h1);
    wr(pcgs_pkg::ADDR_DEN, 32'h0, 1'h1);
    wr(pcgs_pkg::ADDR_DEN, 32'h8000_0000, 1'h1);
    wr(pcgs_pkg::ADDR_SMOOTH, 32'h3E9, 1'h1);
    wr(pcgs_pkg::ADDR_SMOOTH, 32'h3E8, 1'h0);
    rdchk(pcgs_pkg::ADDR_SMOOTH, 32'h3E8);
  endtask

  task automatic t_smooth;
    int i;
    wr(pcgs_pkg::ADDR_SMOOTH, 32'h1, 1'h0);
    pulses(60, 1'h0, 4'h0);
    chk({47'h0, pos_cmd < gear_pos}, 48'h1);
    for (i = 0; i < 4000; i++) begin
      @(negedge pclk);
      if (pos_cmd === 48'h2E) break;
    end
    if (i == 4000) begin
      errors++;
      results();
    end
    chk(pos_cmd, 48'h2E);
    wr(pcgs_pkg::ADDR_SMOOTH, 32'h0, 1'h0);
    pulses(2, 1'h1, 4'h0);
    chk(pos_cmd, 48'h2D);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    presetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    start = 1'h0;
    count = 16'h0;
    dir = 1'h0;
    gap = 4'h0;
    extra = '{32'h3, 32'h5, 32'h7};
    errors = 0;
    checked = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    t_regs();
    t_gear();
    t_lock();
    t_smooth();
    results();
  end
endmodule

`default_nettype wire
